// file: pkg/dcsa_pkg.sv
package dcsa_pkg;
  // Byte positions of each field in the input assembly, little-endian
  localparam int unsigned OFF_FIXED = 4;
  localparam int unsigned OFF_ALARM = 6;
  localparam int unsigned OFF_FB_POS = 8;
  localparam int unsigned OFF_SPEED = 12;
  localparam int unsigned OFF_CMD_POS = 16;
  localparam int unsigned OFF_TORQUE = 20;
  localparam int unsigned OFF_CST = 22;
  localparam int unsigned OFF_INFO = 24;
  localparam int unsigned OFF_RD_ID = 30;
  localparam int unsigned OFF_RW_STAT = 32;
  localparam int unsigned OFF_WR_ID = 34;
  localparam int unsigned OFF_RD_DATA = 36;
  localparam int unsigned OFF_MON0 = 40;
  localparam int unsigned MON_STRIDE = 4;
  localparam int unsigned IMG_BYTES = 56;
  localparam int unsigned NUM_MON = 4;

  // Fixed status word bit positions
  localparam int unsigned FS_SEQ = 0;
  localparam int unsigned FS_MOVE = 1;
  localparam int unsigned FS_IN_POS = 2;
  localparam int unsigned FS_START = 3;
  localparam int unsigned FS_HOME = 4;
  localparam int unsigned FS_READY = 5;
  localparam int unsigned FS_DRDY = 6;
  localparam int unsigned FS_ALARM = 7;
  localparam int unsigned FS_TRIG = 8;
  localparam int unsigned FS_TRIG_KIND = 9;
  localparam int unsigned FS_SET_ERR = 10;
  localparam int unsigned FS_EXEC_ERR = 11;
  localparam int unsigned FS_BUF_OCC = 12;
  localparam int unsigned FS_STOP = 13;
  localparam int unsigned FS_STO_MON = 14;
  localparam int unsigned FS_TLC = 15;

  // Read/write status bit positions
  localparam int unsigned RW_RD_ERR = 7;
  localparam int unsigned RW_WR_END = 8;
  localparam int unsigned RW_BUSY = 9;
  localparam int unsigned RW_RANGE = 11;
  localparam int unsigned RW_IF = 12;
  localparam int unsigned RW_NVM = 13;
  localparam int unsigned RW_EXEC = 14;
  localparam int unsigned RW_WR_ERR = 15;

  // Write failure cause vector: range, interface, nvm, command
  localparam int unsigned CAUSE_W = 4;
  localparam int unsigned SET_ERR_W = 7;
  localparam logic [15:0] RESET_WORD = 16'h0000;

  typedef enum logic [1:0] {WR_IDLE, WR_WAIT, WR_DONE} dcsa_wr_state_t;
endpackage

// file: src/dcsa_top.sv
`timescale 1ns/10ps
// Contract
// - Fixed bit 0 high while a stored-data sequence runs.
// - Fixed bit 1 while motor moves; bit 2 when positioning completes.
// - Fixed bit 4 when homing of either kind or preset is done.
// - Fixed bit 5 ready to operate; bit 6 ready for direct start.
// - Fixed bit 7 reports alarm, active when an alarm is present.
// - Fixed bits 3, 8, 9, 13 echo start, trigger, trigger kind, stop.
// - Fixed bit 10 set when any direct-operation setting is invalid.
// - Fixed bit 11 set when a direct operation cannot execute.
// - Fixed bit 12 high while the direct buffer is being written.
// - Fixed bit 14 from either torque-off input off until re-excited.
// - Fixed bit 15 while torque sits at its upper limit.
// - Report active alarm code, 16 bits, and info code, 32 bits.
// - Report feedback and command position, wrapped when wrap enabled.
// - Report feedback speed in hertz, 32 bits.
// - Report torque and constant-current figure, 0.1 percent per count.
// - Echo read and write ids; return value for echoed read id.
// - Status bit 7 set on failed read, cleared by a good read.
// - Bit 8 high on write done, held while request stays high.
// - Bit 15 on write failure, cleared when the request drops after done.
// - Bits 11 to 14 flag range, interface, memory, command failures.
// - Bit 9 while internally busy; bits 0 to 6 and 10 zero.
// - Four monitor words, each the parameter its address selects.
// - Whole assembly at fixed byte positions, little-endian.
module dcsa_top
  import dcsa_pkg::*;
#(
  parameter int unsigned ID_W = 16,
  parameter int unsigned DATA_W = 32
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Drive state flags
  input wire logic sequence_running,
  input wire logic motor_moving,
  input wire logic positioning_done,
  input wire logic homing_done,
  input wire logic preset_done,
  input wire logic drive_ready,
  input wire logic direct_op_ready,
  input wire logic alarm_active,
  input wire logic [SET_ERR_W-1:0] direct_set_fault,
  input wire logic direct_exec_fault,
  input wire logic direct_buffer_occupied,
  input wire logic torque_limit_reached,
  input wire logic motor_excited,
  input wire logic internal_busy,
  // Safe torque off pins, high means on
  input wire logic safe_torque_off_in_a,
  input wire logic safe_torque_off_in_b,
  // Drive measurements
  input wire logic [15:0] alarm_code,
  input wire logic [31:0] info_code,
  input wire logic wrap_enable,
  input wire logic [31:0] fb_pos_linear,
  input wire logic [31:0] fb_pos_wrapped,
  input wire logic [31:0] cmd_pos_linear,
  input wire logic [31:0] cmd_pos_wrapped,
  input wire logic [31:0] fb_speed_hz,
  input wire logic [15:0] torque_level,
  input wire logic [15:0] constant_current_mode_level,
  // Scanner commands from the cyclic output side
  input wire logic cmd_start,
  input wire logic cmd_trigger,
  input wire logic cmd_trigger_kind,
  input wire logic cmd_stop,
  input wire logic [ID_W-1:0] read_id,
  input wire logic write_req,
  input wire logic [ID_W-1:0] write_id,
  input wire logic [DATA_W-1:0] write_data,
  // Parameter store read port
  output logic [ID_W-1:0] prm_rd_id_r,
  input wire logic prm_rd_ok,
  input wire logic prm_rd_fail,
  input wire logic [DATA_W-1:0] prm_rd_value,
  // Parameter store write port
  output logic prm_wr_strobe_r,
  output logic [ID_W-1:0] prm_wr_id_r,
  output logic [DATA_W-1:0] prm_wr_data_r,
  input wire logic prm_wr_done,
  input wire logic [CAUSE_W-1:0] prm_wr_cause,
  // Monitor lookup
  input wire logic [NUM_MON*ID_W-1:0] mon_addr_cfg,
  output logic [NUM_MON*ID_W-1:0] mon_lookup_id_r,
  input wire logic [NUM_MON*DATA_W-1:0] mon_lookup_value,
  // Assembly byte read port
  input wire logic [5:0] byte_addr,
  output logic [7:0] byte_data_r
);

  logic sto_a_meta_r;
  logic sto_a_r;
  logic sto_b_meta_r;
  logic sto_b_r;
  logic torque_off_r;
  logic [15:0] fixed_r;
  logic [15:0] alarm_r;
  logic [31:0] info_r;
  logic [31:0] fb_pos_r;
  logic [31:0] cmd_pos_r;
  logic [31:0] speed_r;
  logic [15:0] torque_r;
  logic [15:0] cst_r;
  logic [ID_W-1:0] rd_id_echo_r;
  logic [DATA_W-1:0] rd_value_r;
  logic rd_err_r;
  logic [ID_W-1:0] wr_id_echo_r;
  logic wr_end_r;
  logic wr_err_r;
  logic [CAUSE_W-1:0] wr_cause_r;
  logic busy_r;
  logic [NUM_MON*DATA_W-1:0] mon_r;
  logic [15:0] rw_status;
  logic [IMG_BYTES*8-1:0] img;
  dcsa_wr_state_t wr_state_r;
  dcsa_wr_state_t wr_state_nxt;

  // Torque-off pins are asynchronous to the drive clock
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sto_a_meta_r <= 1'b1;
      sto_a_r <= 1'b1;
      sto_b_meta_r <= 1'b1;
      sto_b_r <= 1'b1;
    end else begin
      sto_a_meta_r <= safe_torque_off_in_a;
      sto_a_r <= sto_a_meta_r;
      sto_b_meta_r <= safe_torque_off_in_b;
      sto_b_r <= sto_b_meta_r;
    end
  end

  // Set wins: a pin still off keeps the monitor up even if excited
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      torque_off_r <= 1'b0;
    end else if (!sto_a_r || !sto_b_r) begin
      torque_off_r <= 1'b1;
    end else if (motor_excited) begin
      torque_off_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      fixed_r <= RESET_WORD;
    end else begin
      fixed_r[FS_SEQ] <= sequence_running;
      fixed_r[FS_MOVE] <= motor_moving;
      fixed_r[FS_IN_POS] <= positioning_done;
      fixed_r[FS_START] <= cmd_start;
      fixed_r[FS_HOME] <= homing_done | preset_done;
      fixed_r[FS_READY] <= drive_ready;
      fixed_r[FS_DRDY] <= direct_op_ready;
      fixed_r[FS_ALARM] <= alarm_active;
      fixed_r[FS_TRIG] <= cmd_trigger;
      fixed_r[FS_TRIG_KIND] <= cmd_trigger_kind;
      fixed_r[FS_SET_ERR] <= |direct_set_fault;
      fixed_r[FS_EXEC_ERR] <= direct_exec_fault;
      fixed_r[FS_BUF_OCC] <= direct_buffer_occupied;
      fixed_r[FS_STOP] <= cmd_stop;
      fixed_r[FS_STO_MON] <= torque_off_r;
      fixed_r[FS_TLC] <= torque_limit_reached;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      alarm_r <= '0;
      info_r <= '0;
      fb_pos_r <= '0;
      cmd_pos_r <= '0;
      speed_r <= '0;
      torque_r <= '0;
      cst_r <= '0;
      busy_r <= 1'b0;
    end else begin
      alarm_r <= alarm_code;
      info_r <= info_code;
      fb_pos_r <= wrap_enable ? fb_pos_wrapped : fb_pos_linear;
      cmd_pos_r <= wrap_enable ? cmd_pos_wrapped : cmd_pos_linear;
      speed_r <= fb_speed_hz;
      torque_r <= torque_level;
      cst_r <= constant_current_mode_level;
      busy_r <= internal_busy;
    end
  end

  // Echo id moves with the value so the scanner never sees a mismatch
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      prm_rd_id_r <= '0;
      rd_id_echo_r <= '0;
      rd_value_r <= '0;
    end else begin
      prm_rd_id_r <= read_id;
      if (prm_rd_ok) begin
        rd_id_echo_r <= prm_rd_id_r;
        rd_value_r <= prm_rd_value;
      end
    end
  end

  // Fail wins over a simultaneous good answer
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rd_err_r <= 1'b0;
    end else if (prm_rd_fail) begin
      rd_err_r <= 1'b1;
    end else if (prm_rd_ok) begin
      rd_err_r <= 1'b0;
    end
  end

  always_comb begin
    wr_state_nxt = wr_state_r;
    case (wr_state_r)
      WR_IDLE: begin
        if (write_req) begin
          wr_state_nxt = WR_WAIT;
        end
      end
      WR_WAIT: begin
        if (prm_wr_done) begin
          wr_state_nxt = WR_DONE;
        end
      end
      WR_DONE: begin
        if (!write_req) begin
          wr_state_nxt = WR_IDLE;
        end
      end
      default: wr_state_nxt = WR_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      wr_state_r <= WR_IDLE;
    end else begin
      wr_state_r <= wr_state_nxt;
    end
  end

  // One store write per request edge; a held request never rewrites
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      prm_wr_strobe_r <= 1'b0;
      prm_wr_id_r <= '0;
      prm_wr_data_r <= '0;
      wr_id_echo_r <= '0;
    end else begin
      prm_wr_strobe_r <= (wr_state_r == WR_IDLE) && write_req;
      wr_id_echo_r <= write_id;
      if ((wr_state_r == WR_IDLE) && write_req) begin
        prm_wr_id_r <= write_id;
        prm_wr_data_r <= write_data;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      wr_end_r <= 1'b0;
      wr_err_r <= 1'b0;
      wr_cause_r <= '0;
    end else if ((wr_state_r == WR_WAIT) && prm_wr_done) begin
      wr_end_r <= 1'b1;
      wr_err_r <= |prm_wr_cause;
      wr_cause_r <= prm_wr_cause;
    end else if ((wr_state_r == WR_DONE) && !write_req) begin
      wr_end_r <= 1'b0;
      wr_err_r <= 1'b0;
      wr_cause_r <= '0;
    end
  end

  // Lookup address and value both registered, two-cycle refresh
  genvar gm;
  generate
    for (gm = 0; gm < NUM_MON; gm++) begin : g_mon
      always_ff @(posedge ref_clk) begin
        if (!resetn) begin
          mon_lookup_id_r[gm*ID_W +: ID_W] <= '0;
          mon_r[gm*DATA_W +: DATA_W] <= '0;
        end else begin
          mon_lookup_id_r[gm*ID_W +: ID_W] <= mon_addr_cfg[gm*ID_W +: ID_W];
          mon_r[gm*DATA_W +: DATA_W] <=
            mon_lookup_value[gm*DATA_W +: DATA_W];
        end
      end
    end
  endgenerate

  always_comb begin
    rw_status = '0;
    rw_status[RW_RD_ERR] = rd_err_r;
    rw_status[RW_WR_END] = wr_end_r;
    rw_status[RW_BUSY] = busy_r;
    rw_status[RW_EXEC:RW_RANGE] = wr_cause_r;
    rw_status[RW_WR_ERR] = wr_err_r;
  end

  // Byte n of the image is bits n*8 up, which gives little-endian
  always_comb begin
    img = '0;
    img[OFF_FIXED*8 +: 16] = fixed_r;
    img[OFF_ALARM*8 +: 16] = alarm_r;
    img[OFF_FB_POS*8 +: 32] = fb_pos_r;
    img[OFF_SPEED*8 +: 32] = speed_r;
    img[OFF_CMD_POS*8 +: 32] = cmd_pos_r;
    img[OFF_TORQUE*8 +: 16] = torque_r;
    img[OFF_CST*8 +: 16] = cst_r;
    img[OFF_INFO*8 +: 32] = info_r;
    img[OFF_RD_ID*8 +: 16] = rd_id_echo_r[15:0];
    img[OFF_RW_STAT*8 +: 16] = rw_status;
    img[OFF_WR_ID*8 +: 16] = wr_id_echo_r[15:0];
    img[OFF_RD_DATA*8 +: 32] = rd_value_r[31:0];
    for (int m = 0; m < NUM_MON; m++) begin
      img[(OFF_MON0 + m*MON_STRIDE)*8 +: 32] = mon_r[m*DATA_W +: 32];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      byte_data_r <= 8'h00;
    end else if (byte_addr < IMG_BYTES) begin
      byte_data_r <= img[byte_addr*8 +: 8];
    end else begin
      byte_data_r <= 8'h00;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  seq_bit_a: assert property (
    sequence_running |=> fixed_r[FS_SEQ])
    else $error("sequence bit not set");
  home_bit_a: assert property (
    (preset_done && !homing_done) |=> fixed_r[FS_HOME])
    else $error("home bit missed preset");
  alarm_bit_a: assert property (
    !alarm_active |=> !fixed_r[FS_ALARM])
    else $error("alarm bit wrongly set");
  set_err_a: assert property (
    (|direct_set_fault) |=> fixed_r[FS_SET_ERR])
    else $error("setting error bit missing");
  // Monitor flop, then status word flop: two edges behind the synced pin
  sto_mon_a: assert property (
    (!sto_a_r || !sto_b_r) |-> ##2 fixed_r[FS_STO_MON])
    else $error("torque off monitor missing");
  rd_err_a: assert property (
    prm_rd_fail |=> rd_err_r)
    else $error("read error not flagged");
  wr_end_hold_a: assert property (
    (wr_end_r && write_req) |=> wr_end_r)
    else $error("write end dropped under request");
  wr_err_clr_a: assert property (
    (wr_state_r == WR_DONE && !write_req) |=> !wr_err_r && !wr_end_r)
    else $error("write error not cleared");
  // Fastest turnaround is wait, done, idle before the next strobe
  wr_once_a: assert property (
    prm_wr_strobe_r |=> !prm_wr_strobe_r [*2])
    else $error("second write strobe");
  // Watched at the byte port so the whole path is covered
  rsv_zero_a: assert property (
    (byte_addr == 6'h20 |=> byte_data_r[6:0] == 7'h00) and
    (byte_addr == 6'h21 |=> !byte_data_r[2]))
    else $error("reserved status bits set");
  byte_map_a: assert property (
    byte_addr == 6'h05 |=> byte_data_r == $past(fixed_r[15:8]))
    else $error("fixed word high byte misplaced");

  wr_ok_c: cover property (
    prm_wr_strobe_r ##[1:20] (wr_end_r && !wr_err_r));
  wr_fail_c: cover property (wr_end_r && wr_err_r);
  rd_fail_c: cover property (prm_rd_fail ##1 prm_rd_ok);
  sto_cycle_c: cover property (
    torque_off_r ##[1:50] !torque_off_r);
endmodule

// file: test/dcsa_store_model.sv
`timescale 1ns/10ps
module dcsa_store_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Read port
  input wire logic [15:0] prm_rd_id_r,
  output logic prm_rd_ok,
  output logic prm_rd_fail,
  output logic [31:0] prm_rd_value,
  // Write port
  input wire logic prm_wr_strobe_r,
  input wire logic [3:0] cause_sel,
  input wire logic [2:0] wr_dly,
  output logic prm_wr_done,
  output logic [3:0] prm_wr_cause,
  // Monitor lookup
  input wire logic [63:0] mon_lookup_id_r,
  output logic [127:0] mon_lookup_value
);
  logic [2:0] cnt_r;
  // Ids with the top bit set are unknown to the store
  assign prm_rd_fail = prm_rd_id_r[15];
  assign prm_rd_ok = !prm_rd_id_r[15];
  // A failed read carries junk, never the last good value
  assign prm_rd_value = prm_rd_id_r[15] ? {~prm_rd_id_r, prm_rd_id_r}
                                        : {prm_rd_id_r, ~prm_rd_id_r};
  assign prm_wr_cause = prm_wr_done ? cause_sel : ~cause_sel;
  always_ff @(posedge ref_clk) begin
    if (!resetn) cnt_r <= 3'h0;
    else if (prm_wr_strobe_r) cnt_r <= wr_dly;
    else if (cnt_r != 3'h0) cnt_r <= cnt_r - 3'h1;
  end
  // Done comes wr_dly cycles after the strobe: 1 is prompt
  assign prm_wr_done = cnt_r == 3'h1;
  for (genvar k = 0; k < 4; k++) begin : g_mon
    assign mon_lookup_value[k*32+:32] =
      {mon_lookup_id_r[k*16+:16], ~mon_lookup_id_r[k*16+:16]};
  end
endmodule

// file: test/testbench.sv
`timescale 1ns/10ps
module testbench;
  import dcsa_pkg::*;
  logic ref_clk, resetn, sequence_running, motor_moving, positioning_done;
  logic homing_done, preset_done, drive_ready, direct_op_ready;
  logic alarm_active, direct_exec_fault, direct_buffer_occupied;
  logic torque_limit_reached, motor_excited, internal_busy, wrap_enable;
  logic safe_torque_off_in_a, safe_torque_off_in_b, cmd_start, cmd_trigger;
  logic cmd_trigger_kind, cmd_stop, write_req, prm_rd_ok, prm_rd_fail;
  logic prm_wr_strobe_r, prm_wr_done;
  logic [6:0] direct_set_fault;
  logic [15:0] alarm_code, torque_level, constant_current_mode_level;
  logic [15:0] read_id, write_id, prm_rd_id_r, prm_wr_id_r;
  logic [31:0] info_code, fb_pos_linear, fb_pos_wrapped, cmd_pos_linear;
  logic [31:0] cmd_pos_wrapped, fb_speed_hz, write_data, prm_rd_value;
  logic [31:0] prm_wr_data_r, g;
  logic [3:0] prm_wr_cause, cause_sel;
  logic [2:0] wr_dly;
  logic [63:0] mon_addr_cfg, mon_lookup_id_r;
  logic [127:0] mon_lookup_value;
  logic [5:0] byte_addr;
  logic [7:0] byte_data_r;
  int errors = 0, compares = 0, cycles = 0;

  dcsa_top dut (.ref_clk, .resetn, .sequence_running, .motor_moving,
    .positioning_done, .homing_done, .preset_done, .drive_ready,
    .direct_op_ready, .alarm_active, .direct_set_fault, .direct_exec_fault,
    .direct_buffer_occupied, .torque_limit_reached, .motor_excited,
    .internal_busy, .safe_torque_off_in_a, .safe_torque_off_in_b,
    .alarm_code, .info_code, .wrap_enable, .fb_pos_linear, .fb_pos_wrapped,
    .cmd_pos_linear, .cmd_pos_wrapped, .fb_speed_hz, .torque_level,
    .constant_current_mode_level, .cmd_start, .cmd_trigger,
    .cmd_trigger_kind, .cmd_stop, .read_id, .write_req, .write_id,
    .write_data, .prm_rd_id_r, .prm_rd_ok, .prm_rd_fail, .prm_rd_value,
    .prm_wr_strobe_r, .prm_wr_id_r, .prm_wr_data_r, .prm_wr_done,
    .prm_wr_cause, .mon_addr_cfg, .mon_lookup_id_r, .mon_lookup_value,
    .byte_addr, .byte_data_r);

  dcsa_store_model store (.ref_clk, .resetn, .prm_rd_id_r, .prm_rd_ok,
    .prm_rd_fail, .prm_rd_value, .prm_wr_strobe_r, .cause_sel, .wr_dly,
    .prm_wr_done, .prm_wr_cause, .mon_lookup_id_r, .mon_lookup_value);

  initial begin
    ref_clk = 0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic print_verdict();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("ERROR %0t: run did not finish", $time);
      print_verdict();
    end
  end

  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // Little-endian: lowest byte first
  task automatic rd(input int off, input int n, output logic [31:0] w);
    w = '0;
    for (int b = 0; b < n; b++) begin
      @(negedge ref_clk) byte_addr = 6'(off + b);
      @(negedge ref_clk) w[b*8+:8] = byte_data_r;
    end
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] e);
    compares++;
    if (got !== e) begin
      errors++;
      $display("ERROR %0t: port got %h expected %h", $time, got, e);
    end
  endtask

  task automatic chk(input int off, input int n, input logic [31:0] e);
    logic [31:0] w;
    rd(off, n, w);
    compares++;
    if (w !== e) begin
      errors++;
      $display("ERROR %0t: byte %0d got %h expected %h", $time, off, w, e);
    end
  endtask

  task automatic fin(input string s);
    $display("%s finished, errors %0d", s, errors);
  endtask

  task automatic drv(input int i, input logic v);
    case (i)
      0: sequence_running = v;
      1: motor_moving = v;
      2: positioning_done = v;
      3: cmd_start = v;
      4: homing_done = v;
      5: drive_ready = v;
      6: direct_op_ready = v;
      7: alarm_active = v;
      8: cmd_trigger = v;
      9: cmd_trigger_kind = v;
      11: direct_exec_fault = v;
      12: direct_buffer_occupied = v;
      13: cmd_stop = v;
      15: torque_limit_reached = v;
      default: ;
    endcase
  endtask

  initial begin
    {sequence_running, motor_moving, positioning_done, homing_done,
     preset_done, drive_ready, direct_op_ready, alarm_active,
     direct_exec_fault, direct_buffer_occupied, torque_limit_reached,
     motor_excited, internal_busy, wrap_enable, cmd_start, cmd_trigger,
     cmd_trigger_kind, cmd_stop, write_req, direct_set_fault, alarm_code,
     info_code, fb_pos_linear, fb_pos_wrapped, cmd_pos_linear,
     cmd_pos_wrapped, fb_speed_hz, torque_level, read_id, write_id,
     constant_current_mode_level, write_data, cause_sel, mon_addr_cfg,
     byte_addr} = '0;
    {safe_torque_off_in_a, safe_torque_off_in_b} = 2'b11;
    wr_dly = 3'h1;
    resetn = 0;
    wt(6);
    resetn = 1;
    chk(OFF_FIXED, 2, 32'h0000_0000);
    chk(OFF_RW_STAT, 2, 32'h0000_0000);
    chk(28, 2, 32'h0000_0000);
    chk(56, 1, 32'h0000_0000);
    fin("reset");
    for (int i = 0; i < 16; i++) if (i != 10 && i != 14) begin
      drv(i, 1);
      wt(3);
      chk(OFF_FIXED, 2, 32'(1 << i));
      drv(i, 0);
    end
    preset_done = 1;
    wt(3);
    chk(OFF_FIXED, 2, 32'h0000_0010);
    preset_done = 0;
    for (int k = 0; k < 7; k++) begin
      direct_set_fault = 7'(1 << k);
      wt(3);
      chk(OFF_FIXED, 2, 32'h0000_0400);
    end
    direct_set_fault = '0;
    // Monitor must outlive the pin: cleared only by re-excitation
    for (int p = 0; p < 2; p++) begin
      motor_excited = 0;
      {safe_torque_off_in_a, safe_torque_off_in_b} = p ? 2'b10 : 2'b01;
      wt(5);
      chk(OFF_FIXED, 2, 32'h0000_4000);
      {safe_torque_off_in_a, safe_torque_off_in_b} = 2'b11;
      wt(5);
      chk(OFF_FIXED, 2, 32'h0000_4000);
      motor_excited = 1;
      wt(5);
      chk(OFF_FIXED, 2, 32'h0000_0000);
    end
    fin("fixed status");
    alarm_code = 16'h1a2b;
    info_code = 32'h8000_0042;
    fb_speed_hz = 32'h0001_86a0;
    torque_level = 16'h03e8;
    constant_current_mode_level = 16'h01f4;
    fb_pos_linear = 32'hffff_ff00;
    fb_pos_wrapped = 32'h0000_0c80;
    cmd_pos_linear = 32'h1234_5678;
    cmd_pos_wrapped = 32'h0000_0640;
    for (int w = 0; w < 2; w++) begin
      wrap_enable = w[0];
      wt(3);
      chk(OFF_FB_POS, 4, w ? 32'h0000_0c80 : 32'hffff_ff00);
      chk(OFF_CMD_POS, 4, w ? 32'h0000_0640 : 32'h1234_5678);
    end
    chk(OFF_ALARM, 2, 32'h0000_1a2b);
    chk(OFF_INFO, 4, 32'h8000_0042);
    chk(OFF_SPEED, 4, 32'h0001_86a0);
    chk(OFF_TORQUE, 2, 32'h0000_03e8);
    chk(OFF_CST, 2, 32'h0000_01f4);
    fin("measurements");
    read_id = 16'h0012;
    wt(4);
    chk(OFF_RD_ID, 2, 32'h0000_0012);
    chk(OFF_RD_DATA, 4, 32'h0012_ffed);
    read_id = 16'h8001;
    wt(4);
    chk(OFF_RW_STAT, 2, 32'h0000_0080);
    chk(OFF_RD_ID, 2, 32'h0000_0012);
    read_id = 16'h0034;
    wt(4);
    chk(OFF_RW_STAT, 2, 32'h0000_0000);
    chk(OFF_RD_DATA, 4, 32'h0034_ffcb);
    internal_busy = 1;
    wt(3);
    chk(OFF_RW_STAT, 2, 32'h0000_0200);
    internal_busy = 0;
    fin("parameter read");
    for (int c = 0; c < 5; c++) begin
      cause_sel = (c == 0) ? 4'h0 : 4'(1 << (c - 1));
      wr_dly = c[0] ? 3'h1 : 3'h6;
      write_id = 16'(16'h0100 + c);
      write_data = 32'hc0de_0000 | 32'(c);
      write_req = 1;
      wt(1);
      chk_val({31'h0, prm_wr_strobe_r}, 32'h0000_0001);
      chk_val({16'h0, prm_wr_id_r}, 32'(16'h0100 + c));
      chk_val(prm_wr_data_r, 32'hc0de_0000 | 32'(c));
      g = '0;
      for (int t = 0; t < 20 && !g[8]; t++) rd(OFF_RW_STAT, 2, g);
      wt(3);
      chk(OFF_RW_STAT, 2, {16'h0, c != 0, cause_sel, 11'h100});
      chk(OFF_WR_ID, 2, 32'(16'h0100 + c));
      write_req = 0;
      wt(3);
      chk(OFF_RW_STAT, 2, 32'h0000_0000);
    end
    fin("parameter write");
    mon_addr_cfg = 64'h0041_0032_0023_0014;
    wt(4);
    for (int k = 0; k < 4; k++)
      chk(OFF_MON0 + MON_STRIDE * k, 4, {mon_addr_cfg[k*16+:16],
          ~mon_addr_cfg[k*16+:16]});
    fin("monitors");
    print_verdict();
  end
endmodule
